// [core/srs_pkg.sv]
// Constants and types for the reset and standby sequencer
package srs_pkg;
   localparam int unsigned CLK_MHZ          = 25;
   // Entry to standby completes no sooner than this, in microseconds
   localparam int unsigned STBY_ENTRY_US    = 20;
   localparam int unsigned STBY_ENTRY_CYC   = STBY_ENTRY_US * CLK_MHZ;
   // Soft reset stretch, in clock cycles; hard reset loads no stretch
   localparam int unsigned SOFT_RST_CYC     = 120;
   localparam int unsigned CNT_W            = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 10'h000;
   localparam logic [CNT_W-1:0] STBY_ENTRY_LEN = CNT_W'(STBY_ENTRY_CYC);
   localparam logic [CNT_W-1:0] SOFT_RST_LEN   = CNT_W'(SOFT_RST_CYC);
   localparam int unsigned OUT_W            = 8;

   typedef enum logic [1:0]
   {
      SRS_STBY_AT_LINE  = 2'h0,
      SRS_STBY_AT_FRAME = 2'h1
   } srs_sync_t;

   // Standby configuration bits written by software
   typedef struct packed
   {
      logic inhibit;
      logic at_frame;
   } srs_stby_cfg_t;

   // Pins from the host
   typedef struct packed
   {
      logic reset_n;
      logic standby;
      logic shutdown;
   } srs_pins_t;

   // Power and domain controls toward the rest of the chip
   typedef struct packed
   {
      logic core_pwr_on;
      logic core_clk_en;
      logic cfg_clear;
      logic all_clear;
      logic serial_en;
      logic sysctrl_only;
      logic fifo_en;
   } srs_ctl_t;

   localparam srs_ctl_t CTL_OFF = '{default: 1'b0};
endpackage

// [core/srs_sequencer.sv]
// Reset, standby and shutdown sequencer for the sensor system-on-chip
// Rules for this block and for the host that drives it
// RULE_01: Host should assert hard reset after power-up.
// RULE_02: Host starts input clock late enough after supply.
// RULE_03: All outputs high impedance during hard reset.
// RULE_04: After reset FIFO disabled, outputs tri-stated.
// RULE_05: Host clocks ten periods around hard reset.
// RULE_06: Host waits hundred clocks before first transaction.
// RULE_07: Register write soft reset equals hard reset.
// RULE_08: Host clocks 120 cycles after soft reset.
// RULE_09: Host reconfigures device after soft reset.
// RULE_10: Configuration bit can block both standby kinds.
// RULE_11: Hard standby removes core power, keeps PLL.
// RULE_12: Hard standby: serial off, sysctrl only, pin resumes.
// RULE_13: Host clocks ten units before standby release.
// RULE_14: Host waits twenty units before first write.
// RULE_15: Soft standby stops core, keeps registers, serial.
// RULE_16: Host requests soft standby after calculations finish.
// RULE_17: Soft standby at line end, optionally frame.
// RULE_18: Host clocks ten units before soft standby release.
// RULE_19: Shutdown drops everything; release gives power-on reset.
// RULE_20: Host counts clock cycles for every wait.
`timescale 1ns/10ps
module srs_sequencer
   import srs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire srs_pins_t     pins,
   input  wire srs_stby_cfg_t stby_cfg,
   input  wire logic          soft_reset_wr,
   input  wire logic          soft_stby_req,
   input  wire logic          soft_stby_rel,
   input  wire logic          out_enable_wr,
   input  wire logic          line_end,
   input  wire logic          frame_end,
   input  wire logic [OUT_W-1:0] core_out,
   output logic [OUT_W-1:0]   pad_out,
   output logic [OUT_W-1:0]   pad_oe,
   output srs_ctl_t           ctl,
   output logic               in_hard_stby,
   output logic               in_soft_stby,
   output logic               in_reset
);
   typedef enum logic [2:0]
   {
      ST_OFF,
      ST_RESET,
      ST_RUN,
      ST_SOFT_WAIT,
      ST_SOFT_ENTER,
      ST_SOFT_STBY,
      ST_HARD_ENTER,
      ST_HARD_STBY
   } srs_state_t;

   srs_state_t       state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             out_en_r, out_en_nxt;
   logic             cfg_lost_r, cfg_lost_nxt;
   srs_ctl_t         ctl_nxt;
   logic [OUT_W-1:0] pad_out_nxt, pad_oe_nxt;

   // True once a countdown has run out
   function automatic logic cnt_done(input logic [CNT_W-1:0] c);
      return c == CNT_ZERO;
   endfunction

   // Boundary pulse that carries out a pending soft standby
   function automatic logic sync_pick(input srs_sync_t mode, input logic line_p, input logic frame_p);
      unique case (mode)
         SRS_STBY_AT_LINE:
            return line_p;
         SRS_STBY_AT_FRAME:
            return frame_p;
         default:
            return 1'b0;
      endcase
   endfunction

   // Soft reset resets exactly what the pin resets
   wire logic any_reset = !pins.reset_n || soft_reset_wr; // RULE_07
   wire logic sync_hit  = sync_pick(srs_sync_t'({1'b0, stby_cfg.at_frame}), line_end, frame_end); // RULE_17

   always_comb
   begin
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      out_en_nxt   = out_en_r;
      cfg_lost_nxt = cfg_lost_r;
      if (pins.shutdown)
      begin
         state_nxt    = ST_OFF; // RULE_19
         out_en_nxt   = 1'b0;
         cfg_lost_nxt = 1'b1;
      end
      else if (any_reset)
      begin
         state_nxt    = ST_RESET; // RULE_03
         cnt_nxt      = soft_reset_wr ? SOFT_RST_LEN : CNT_ZERO;
         out_en_nxt   = 1'b0; // RULE_04
         cfg_lost_nxt = 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_OFF:
            begin
               state_nxt    = ST_RESET; // RULE_19
               cnt_nxt      = CNT_ZERO;
               cfg_lost_nxt = 1'b0;
            end
            ST_RESET:
               if (!cnt_done(cnt_r))
                  cnt_nxt = cnt_r - CNT_W'(1);
               else
                  state_nxt = ST_RUN;
            ST_RUN:
            begin
               if (out_enable_wr)
                  out_en_nxt = 1'b1; // RULE_04
               if (pins.standby && !stby_cfg.inhibit) // RULE_10
               begin
                  state_nxt = ST_HARD_ENTER;
                  cnt_nxt   = STBY_ENTRY_LEN;
               end
               else if (soft_stby_req && !stby_cfg.inhibit) // RULE_10
                  state_nxt = ST_SOFT_WAIT;
            end
            ST_SOFT_WAIT:
               if (sync_hit) // RULE_17
               begin
                  state_nxt = ST_SOFT_ENTER;
                  cnt_nxt   = STBY_ENTRY_LEN;
               end
            ST_SOFT_ENTER:
               if (!cnt_done(cnt_r))
                  cnt_nxt = cnt_r - CNT_W'(1);
               else
                  state_nxt = ST_SOFT_STBY;
            ST_SOFT_STBY:
               if (soft_stby_rel)
                  state_nxt = ST_RUN; // RULE_15
            ST_HARD_ENTER:
               if (!pins.standby)
                  state_nxt = ST_RUN;
               else if (!cnt_done(cnt_r))
                  cnt_nxt = cnt_r - CNT_W'(1);
               else
               begin
                  state_nxt    = ST_HARD_STBY;
                  cfg_lost_nxt = 1'b1; // RULE_11
               end
            ST_HARD_STBY:
               if (!pins.standby)
                  state_nxt = ST_RUN; // RULE_12
         endcase
      end
   end

   always_comb
   begin
      ctl_nxt     = CTL_OFF;
      pad_out_nxt = '0;
      pad_oe_nxt  = '0;
      unique case (state_nxt)
         ST_OFF:
            ctl_nxt.all_clear = 1'b1; // RULE_19
         ST_RESET:
         begin
            ctl_nxt.core_pwr_on = 1'b1;
            ctl_nxt.cfg_clear   = 1'b1; // RULE_03
         end
         ST_RUN, ST_SOFT_WAIT:
         begin
            ctl_nxt.core_pwr_on = 1'b1;
            ctl_nxt.core_clk_en = 1'b1;
            ctl_nxt.serial_en   = 1'b1;
            ctl_nxt.cfg_clear   = cfg_lost_nxt;
            ctl_nxt.fifo_en     = out_en_nxt;
            if (out_en_nxt)
            begin
               pad_out_nxt = core_out;
               pad_oe_nxt  = {OUT_W{1'b1}}; // RULE_04
            end
         end
         ST_SOFT_ENTER, ST_SOFT_STBY:
         begin
            ctl_nxt.core_pwr_on = 1'b1; // RULE_15
            ctl_nxt.serial_en   = 1'b1;
         end
         ST_HARD_ENTER:
         begin
            ctl_nxt.core_pwr_on = 1'b1;
            ctl_nxt.serial_en   = 1'b1;
         end
         ST_HARD_STBY:
            ctl_nxt.sysctrl_only = 1'b1; // RULE_12
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r      <= ST_RESET;
         cnt_r        <= CNT_ZERO;
         out_en_r     <= 1'b0;
         cfg_lost_r   <= 1'b0;
         ctl          <= CTL_OFF;
         pad_out      <= '0;
         pad_oe       <= '0;
         in_hard_stby <= 1'b0;
         in_soft_stby <= 1'b0;
         in_reset     <= 1'b1;
      end
      else
      begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         out_en_r     <= out_en_nxt;
         cfg_lost_r   <= cfg_lost_nxt;
         ctl          <= ctl_nxt;
         pad_out      <= pad_out_nxt;
         pad_oe       <= pad_oe_nxt;
         in_hard_stby <= (state_nxt == ST_HARD_STBY);
         in_soft_stby <= (state_nxt == ST_SOFT_STBY);
         in_reset     <= (state_nxt == ST_RESET) || (state_nxt == ST_OFF);
      end
   end
endmodule

// [tb/srs_host.sv]
// Host model driving the reset, standby and shutdown pins
`timescale 1ns/10ps
module srs_host
   import srs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_req,
   input  wire logic stby_req,
   input  wire logic shd_req,
   output srs_pins_t pins
);
   logic [6:0] low_r  = 7'h00;
   srs_pins_t  pins_r = 3'h4;
   assign pins = pins_r;
   // Once asserted, reset stays low for at least 70 clocks
   always_ff @(posedge clk)
   begin
      low_r  <= ((rst_req || low_r != 7'h00) && low_r < 7'h46) ? low_r + 7'h01 : 7'h00;
      pins_r <= '{!(rst_req || low_r != 7'h00), stby_req, shd_req};
   end
endmodule

// [tb/srs_sequencer_chk.sv]
// Port assertions for the reset and standby sequencer
`timescale 1ns/10ps
module srs_sequencer_chk
   import srs_pkg::*;
(
   input wire logic             clk,
   input wire logic             reset,
   input wire srs_pins_t        pins,
   input wire logic             soft_reset_wr,
   input wire logic [OUT_W-1:0] pad_oe,
   input wire srs_ctl_t         ctl,
   input wire logic             in_hard_stby,
   input wire logic             in_soft_stby,
   input wire logic             in_reset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_rst_hiz: assert property (!pins.reset_n |=> pad_oe == '0)
      else $error("pads driven in reset");
   chk_rst_fifo_off: assert property (in_reset |-> pad_oe == '0 && !ctl.fifo_en)
      else $error("fifo on in reset");
   chk_soft_rst: assert property (soft_reset_wr && !pins.shutdown |=> in_reset && ctl.cfg_clear)
      else $error("soft reset missed");
   chk_hstby_pwr: assert property (in_hard_stby |-> !ctl.core_pwr_on)
      else $error("core power on");
   chk_hstby_serial: assert property (in_hard_stby |-> !ctl.serial_en && ctl.sysctrl_only)
      else $error("serial on in standby");
   chk_hstby_exit: assert property (in_hard_stby && !pins.standby |=> !in_hard_stby)
      else $error("standby not left");
   chk_sstby_keep: assert property (in_soft_stby |-> ctl.serial_en && !ctl.core_clk_en)
      else $error("soft standby controls");
   chk_sstby_entry: assert property ($rose(in_soft_stby) |-> $past(ctl.core_clk_en, 300) == 1'b0)
      else $error("soft entry too short");
   chk_shut_off: assert property (pins.shutdown |=> !ctl.core_pwr_on && pad_oe == '0)
      else $error("power in shutdown");
   chk_shut_por: assert property ($fell(pins.shutdown) |=> in_reset && ctl.core_pwr_on && !ctl.all_clear)
      else $error("no reset after shutdown");
   cov_soft: cover property ($rose(in_soft_stby));
   cov_hard: cover property ($rose(in_hard_stby));
   cov_shut: cover property ($fell(pins.shutdown));
endmodule
bind srs_sequencer srs_sequencer_chk u_chk (.clk, .reset, .pins, .soft_reset_wr, .pad_oe, .ctl, .in_hard_stby,
   .in_soft_stby, .in_reset);

// [tb/tb_srs_sequencer.sv]
// Self-checking bench for the reset and standby sequencer
`timescale 1ns/10ps
module tb_srs_sequencer
   import srs_pkg::*;
;
   logic             clk = 0, reset = 1, rq = 1, sq = 0, dq = 0, srw = 0;
   logic             ssr = 0, ssl = 0, oew = 0, le = 0, fe = 0, ihs, iss, ir;
   srs_stby_cfg_t    cfg = '0;
   srs_pins_t        pins;
   srs_ctl_t         ctl;
   logic [OUT_W-1:0] po, oe;
   int               err_total = 0, n_compared = 0;
   srs_host u_host (.clk, .rst_req(rq), .stby_req(sq), .shd_req(dq), .pins);
   srs_sequencer u_dut (.clk, .reset, .pins, .stby_cfg(cfg), .soft_reset_wr(srw), .soft_stby_req(ssr),
      .soft_stby_rel(ssl), .out_enable_wr(oew), .line_end(le), .frame_end(fe), .core_out(8'ha5),
      .pad_out(po), .pad_oe(oe), .ctl, .in_hard_stby(ihs), .in_soft_stby(iss), .in_reset(ir));
   // Supplies are taken as settled before time zero, so the clock may start at once
   initial forever #20 clk = ~clk;
   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      n_compared++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_st(logic [2:0] w, int lim);
      #1;
      repeat (lim)
         if ({ir, ihs, iss} !== w)
            cyc(1);
      chk("state", {ir, ihs, iss}, w);
      if ({ir, ihs, iss} !== w)
         print_verdict();
   endtask
   task automatic t_hard();
      cyc(3);
      chk("oe", oe, 8'h00);
      @(posedge clk) rq <= 1'b0;
      wait_st(3'b000, 90);
      chk("fifo", ctl.fifo_en, 8'h00);
      chk("oe", oe, 8'h00);
      cyc(100);
      chk("oe", oe, 8'h00);
      @(posedge clk) oew <= 1'b1;
      @(posedge clk) oew <= 1'b0;
      cyc(2);
      chk("oe", oe, 8'hff);
      chk("pad", po, 8'ha5);
   endtask
   task automatic t_soft_rst();
      @(posedge clk) srw <= 1'b1;
      @(posedge clk) srw <= 1'b0;
      #1;
      chk("rst", ir, 8'h01);
      chk("oe", oe, 8'h00);
      cyc(100);
      chk("rst", ir, 8'h01);
      wait_st(3'b000, 30);
      chk("oe", oe, 8'h00);
      chk("fifo", ctl.fifo_en, 8'h00);
      cyc(100);
      @(posedge clk) oew <= 1'b1;
      @(posedge clk) oew <= 1'b0;
      cyc(2);
      chk("oe", oe, 8'hff);
   endtask
   // Line end comes first; only the frame end may start entry in frame mode
   task automatic t_sstby(logic af);
      @(posedge clk) cfg <= '{1'b0, af};
      ssr <= 1'b1;
      @(posedge clk) ssr <= 1'b0;
      le <= 1'b1;
      @(posedge clk) le <= 1'b0;
      cyc(3);
      chk("clk_en", ctl.core_clk_en, {7'h00, af});
      @(posedge clk) fe <= 1'b1;
      @(posedge clk) fe <= 1'b0;
      wait_st(3'b001, 520);
      chk("serial", ctl.serial_en, 8'h01);
      cyc(10);
      @(posedge clk) ssl <= 1'b1;
      @(posedge clk) ssl <= 1'b0;
      wait_st(3'b000, 10);
      chk("oe", oe, 8'hff);
   endtask
   task automatic t_hstby();
      @(posedge clk) cfg <= '{1'b1, 1'b0};
      sq <= 1'b1;
      ssr <= 1'b1;
      @(posedge clk) ssr <= 1'b0;
      le <= 1'b1;
      @(posedge clk) le <= 1'b0;
      cyc(600);
      wait_st(3'b000, 1);
      chk("clk_en", ctl.core_clk_en, 8'h01);
      @(posedge clk) cfg <= '0;
      wait_st(3'b010, 520);
      chk("pwr", ctl.core_pwr_on, 8'h00);
      chk("sysctrl", ctl.sysctrl_only, 8'h01);
      cyc(10);
      @(posedge clk) sq <= 1'b0;
      wait_st(3'b000, 10);
      chk("cfg_lost", ctl.cfg_clear, 8'h01);
      cyc(20);
      @(posedge clk) oew <= 1'b1;
      @(posedge clk) oew <= 1'b0;
      cyc(2);
      chk("oe", oe, 8'hff);
   endtask
   task automatic t_shut();
      @(posedge clk) dq <= 1'b1;
      cyc(5);
      chk("pwr", ctl.core_pwr_on, 8'h00);
      chk("all_clear", ctl.all_clear, 8'h01);
      @(posedge clk) dq <= 1'b0;
      cyc(2);
      chk("rst", ir, 8'h01);
      chk("pwr", ctl.core_pwr_on, 8'h01);
      chk("all_clear", ctl.all_clear, 8'h00);
      wait_st(3'b000, 200);
      chk("oe", oe, 8'h00);
      chk("cfg_lost", ctl.cfg_clear, 8'h00);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      @(posedge clk) reset <= 1'b0;
      t_hard();
      t_soft_rst();
      t_sstby(1'b1);
      t_sstby(1'b0);
      t_hstby();
      t_shut();
      print_verdict();
   end
endmodule
